// ---- src/sicr_regs.sv ----
// status, interrupt and checksum register group of the dual-interface tag
//
// Behaviour
// [RULE1] status bit 0 shows memory update readiness
// [RULE2] status bit 1 high while checksum runs
// [RULE3] status bit 2 shows radio activity
// [RULE4] status bits 3-15 zero; flags reset zero
// [RULE5] enable register read/write, resets zero
// [RULE6] interrupt is OR of enabled pending flags
// [RULE7] flag register reads pending events, resets zero
// [RULE8] writing one clears flag, zero keeps
// [RULE9] flag 1 on field off after read
// [RULE10] flag 2 on field off after write
// [RULE11] flag 3 when checksum result ready
// [RULE12] flag 4 on parity fault in mode
// [RULE13] flag 5 on invalid message at enable
// [RULE14] flag 7 on any device fault
// [RULE15] checksum over programmed start and length
// [RULE16] length register read/write, bit 0 zero
// [RULE17] length high byte write launches checksum
// [RULE18] result readable, low byte lower address
// [RULE19] start address split low/high bytes
// [RULE20] host launches only with radio disabled; the code launches whatever radio_activity_i shows
// [RULE21] polynomial 0x1021, preset all ones
// [RULE22] start address even, resets zero
// [RULE23] pin released unless output enable set
// [RULE24] polarity bit selects active low/high
// [RULE25] busy drops as completion flag sets
// [RULE26] enabling pending flag asserts interrupt immediately
`timescale 1ns/1ns
module sicr_regs
  import sicr_pkg::*;
#(
  parameter int ADDR_W = 16 // message memory address width
)
(
  input wire logic core_clk_i, // 50 MHz core clock
  input wire logic srst_i, // synchronous reset, active high
  // byte register port from the serial interface logic
  input wire logic reg_wr_i, // write strobe, one cycle
  input wire logic reg_rd_i, // read strobe, one cycle
  input wire logic [15:0] reg_addr_i, // byte address
  input wire logic [7:0] reg_wdata_i, // write byte
  output logic [7:0] reg_rdata_o, // read byte, valid cycle after reg_rd_i
  // message memory read port for the checksum
  output logic mem_rd_o, // read request
  output logic [ADDR_W-1:0] mem_addr_o, // byte address
  input wire logic [7:0] mem_rdata_i, // byte, one cycle after mem_rd_o
  // device state and events
  input wire logic msg_mem_ready_i, // memory accepts serial updates
  input wire logic radio_activity_i, // radio communication ongoing
  input wire logic reader_read_done_i, // field off after a read, pulse
  input wire logic reader_write_done_i, // field off after a write, pulse
  input wire logic interleaved_parity_mode_i, // parity transfer mode on
  input wire logic interleaved_parity_fault_i, // parity fault seen, pulse
  input wire logic msg_structure_fault_i, // invalid message at radio_if_enable, pulse
  input wire logic generic_fault_i, // unreliable device, pulse
  // interrupt pin configuration from the general control register
  input wire logic int_pin_enable_i, // 1 lets the pin be driven
  input wire logic int_active_high_i, // 1 active high, 0 active low
  input wire logic int_drive_idle_i, // 1 drives idle level, 0 releases it
  // interrupt pin
  output logic int_pin_o, // pin level when driven
  output logic int_pin_oe_o, // high while the pin is driven
  output logic int_pending_o // internal interrupt, active high
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] start_addr; // checksum start address
  logic [15:0] length; // checksum length in bytes
  logic [15:0] result; // last checksum
  logic [15:0] flags; // pending events
  logic [15:0] enables; // interrupt enables
  logic [15:0] crc; // running checksum
  logic [15:0] remain; // bytes left to fold in
  logic [ADDR_W-1:0] fetch_addr; // next memory byte
  sicr_state_t state; // checksum engine state

  // ----------------------------------------
  // byte-wide checksum step, msb first
  // ----------------------------------------
  function automatic logic [15:0] crc_byte(input logic [15:0] c_in, input logic [7:0] d);
    logic [15:0] c;
    c = c_in;
    for (int i = 7; i >= 0; i--)
    begin
      if (c[15] ^ d[i]) // RULE21
        c = {c[14:0], 1'b0} ^ SICR_CRC_POLY;
      else
        c = {c[14:0], 1'b0};
    end
    return c;
  endfunction : crc_byte

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  wire wr_start_lo = reg_wr_i && (reg_addr_i == SICR_ADDR_START_LO); // start low
  wire wr_start_hi = reg_wr_i && (reg_addr_i == SICR_ADDR_START_HI); // start high
  wire wr_len_lo = reg_wr_i && (reg_addr_i == SICR_ADDR_LEN_LO); // length low
  wire wr_len_hi = reg_wr_i && (reg_addr_i == SICR_ADDR_LEN_HI); // length high
  wire wr_flag_lo = reg_wr_i && (reg_addr_i == SICR_ADDR_FLAG_LO); // flags low
  wire wr_flag_hi = reg_wr_i && (reg_addr_i == SICR_ADDR_FLAG_HI); // flags high
  wire wr_en_lo = reg_wr_i && (reg_addr_i == SICR_ADDR_EN_LO); // enables low
  wire wr_en_hi = reg_wr_i && (reg_addr_i == SICR_ADDR_EN_HI); // enables high

  // ----------------------------------------
  // status word
  // ----------------------------------------
  wire busy = (state != SICR_IDLE); // RULE2
  wire [15:0] status = {13'h0000, radio_activity_i, busy, msg_mem_ready_i}; // RULE1 RULE3 RULE4

  // ----------------------------------------
  // read mux, reserved addresses read zero
  // ----------------------------------------
  logic [7:0] rd_mux; // byte selected by the address
  always_comb
  begin
    case (reg_addr_i)
      SICR_ADDR_START_LO: rd_mux = start_addr[7:0];
      SICR_ADDR_START_HI: rd_mux = start_addr[15:8];
      SICR_ADDR_LEN_LO: rd_mux = length[7:0];
      SICR_ADDR_LEN_HI: rd_mux = length[15:8];
      SICR_ADDR_RES_LO: rd_mux = result[7:0]; // RULE18
      SICR_ADDR_RES_HI: rd_mux = result[15:8]; // RULE18
      SICR_ADDR_FLAG_LO: rd_mux = flags[7:0]; // RULE7
      SICR_ADDR_FLAG_HI: rd_mux = flags[15:8];
      SICR_ADDR_EN_LO: rd_mux = enables[7:0];
      SICR_ADDR_EN_HI: rd_mux = enables[15:8];
      SICR_ADDR_STAT_LO: rd_mux = status[7:0];
      SICR_ADDR_STAT_HI: rd_mux = status[15:8];
      default: rd_mux = 8'h00; // unmapped byte
    endcase
  end

  // read data held until the next read
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
      reg_rdata_o <= rd_mux;
  end

  // ----------------------------------------
  // checksum parameters
  // ----------------------------------------
  // bit 0 of both is forced low so every range is word aligned
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      start_addr <= SICR_RST_REG; // RULE22
      length <= SICR_RST_REG; // RULE16
    end
    else
    begin
      if (wr_start_lo)
        start_addr[7:0] <= {reg_wdata_i[7:1], 1'b0}; // RULE19 RULE22
      if (wr_start_hi)
        start_addr[15:8] <= reg_wdata_i; // RULE19
      if (wr_len_lo)
        length[7:0] <= {reg_wdata_i[7:1], 1'b0}; // RULE16
      if (wr_len_hi)
        length[15:8] <= reg_wdata_i; // RULE16
    end
  end

  // ----------------------------------------
  // checksum engine
  // ----------------------------------------
  // a launch while running is ignored; the running range is already latched
  wire [15:0] launch_len = {reg_wdata_i, length[7:0]}; // length including the new high byte
  wire launch = wr_len_hi && !busy; // RULE17
  wire last_byte = (state == SICR_ACCUM) && (remain == 16'h0001); // final fold
  wire crc_done = last_byte || (launch && (launch_len == 16'h0000)); // RULE11
  wire [15:0] crc_next = crc_byte(crc, mem_rdata_i); // RULE21

  assign mem_rd_o = (state == SICR_FETCH); // one byte per two cycles
  assign mem_addr_o = fetch_addr;

  // engine sequencing
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      state <= SICR_IDLE;
      crc <= SICR_CRC_PRESET;
      remain <= SICR_RST_REG;
      fetch_addr <= '0;
      result <= SICR_RST_REG;
    end
    else
    begin
      case (state)
        SICR_IDLE:
        begin
          if (launch)
          begin
            crc <= SICR_CRC_PRESET; // RULE21
            remain <= launch_len; // RULE15
            fetch_addr <= start_addr[ADDR_W-1:0]; // RULE15
            if (launch_len == 16'h0000)
              result <= SICR_CRC_PRESET; // empty range yields the preset
            else
              state <= SICR_FETCH;
          end
        end
        SICR_FETCH:
          state <= SICR_ACCUM;
        SICR_ACCUM:
        begin
          crc <= crc_next; // RULE15
          remain <= remain - 16'h0001;
          fetch_addr <= fetch_addr + 1'b1;
          if (last_byte)
          begin
            result <= crc_next; // RULE18
            state <= SICR_IDLE; // RULE25
          end
          else
            state <= SICR_FETCH;
        end
        default:
          state <= SICR_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // pending flags
  // ----------------------------------------
  // a set in the cycle of its clear wins, so no event is lost
  logic [15:0] ev_set; // events of this cycle
  always_comb
  begin
    ev_set = 16'h0000;
    ev_set[SICR_FL_READ_DONE] = reader_read_done_i; // RULE9
    ev_set[SICR_FL_WRITE_DONE] = reader_write_done_i; // RULE10
    ev_set[SICR_FL_CRC_DONE] = crc_done; // RULE11 RULE25
    ev_set[SICR_FL_PARITY] = interleaved_parity_fault_i && interleaved_parity_mode_i; // RULE12
    ev_set[SICR_FL_STRUCT] = msg_structure_fault_i; // RULE13
    ev_set[SICR_FL_GENERIC] = generic_fault_i; // RULE14
  end

  wire [15:0] ev_clr = {wr_flag_hi ? reg_wdata_i : 8'h00,
                        wr_flag_lo ? reg_wdata_i : 8'h00}; // RULE8
  wire [15:0] next_flags = ((flags & ~ev_clr) | ev_set) & SICR_FLAG_IMPL; // RULE8 RULE14

  // flag store
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      flags <= SICR_RST_REG; // RULE7
    else
      flags <= next_flags;
  end

  // enable store, every bit writable
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      enables <= SICR_RST_REG; // RULE5
    else
    begin
      if (wr_en_lo)
        enables[7:0] <= reg_wdata_i; // RULE5
      if (wr_en_hi)
        enables[15:8] <= reg_wdata_i; // RULE5
    end
  end

  // ----------------------------------------
  // interrupt pin
  // ----------------------------------------
  // level follows the registers directly, so a new enable acts at once
  assign int_pending_o = |(flags & enables); // RULE6 RULE26
  assign int_pin_o = int_active_high_i ? int_pending_o : !int_pending_o; // RULE24
  assign int_pin_oe_o = int_pin_enable_i && (int_pending_o || int_drive_idle_i); // RULE23

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_launch_nonzero;
    launch && (launch_len != 16'h0000);
  endsequence

  sequence s_two_byte_run;
    busy [*4] ##1 !busy;
  endsequence

  a_ready_mirror: assert property (@(posedge core_clk_i) disable iff (srst_i)
    reg_rd_i && reg_addr_i == SICR_ADDR_STAT_LO |=> reg_rdata_o[0] == $past(msg_mem_ready_i)) // RULE1
    else $error("status bit 0 does not follow memory readiness");

  a_busy_launch: assert property (@(posedge core_clk_i) disable iff (srst_i)
    s_launch_nonzero |=> busy) // RULE2 RULE17
    else $error("launch did not start the checksum");

  a_two_byte_len: assert property (@(posedge core_clk_i) disable iff (srst_i)
    launch && launch_len == 16'h0002 |=> s_two_byte_run) // RULE15
    else $error("two byte checksum took the wrong number of cycles");

  a_radio_status: assert property (@(posedge core_clk_i) disable iff (srst_i)
    reg_rd_i && reg_addr_i == SICR_ADDR_STAT_LO
      |=> reg_rdata_o[7:3] == 5'h00 && reg_rdata_o[2] == $past(radio_activity_i)) // RULE3 RULE4
    else $error("status radio bit or reserved bits wrong");

  a_irq_or: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $rose(flags[SICR_FL_CRC_DONE]) && enables[SICR_FL_CRC_DONE] |-> int_pending_o) // RULE6
    else $error("enabled flag did not raise the interrupt");

  a_w1c_clear: assert property (@(posedge core_clk_i) disable iff (srst_i)
    wr_flag_lo && reg_wdata_i[SICR_FL_GENERIC] && !generic_fault_i
      |=> !flags[SICR_FL_GENERIC]) // RULE8
    else $error("write one did not clear the flag");

  a_set_wins: assert property (@(posedge core_clk_i) disable iff (srst_i)
    wr_flag_lo && reg_wdata_i[SICR_FL_WRITE_DONE] && reader_write_done_i
      |=> flags[SICR_FL_WRITE_DONE]) // RULE10
    else $error("event lost against a clear");

  a_zero_keeps: assert property (@(posedge core_clk_i) disable iff (srst_i)
    wr_flag_lo && !reg_wdata_i[SICR_FL_READ_DONE] && flags[SICR_FL_READ_DONE]
      |=> flags[SICR_FL_READ_DONE]) // RULE8 RULE9
    else $error("write zero changed a flag");

  a_parity_gate: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !flags[SICR_FL_PARITY] && !interleaved_parity_mode_i |=> !flags[SICR_FL_PARITY]) // RULE12
    else $error("parity flag set outside parity mode");

  a_done_busy: assert property (@(posedge core_clk_i) disable iff (srst_i)
    busy ##1 !busy |-> $rose(flags[SICR_FL_CRC_DONE]) || $past(flags[SICR_FL_CRC_DONE])) // RULE25
    else $error("busy fell without completion flag");

  a_struct_flag: assert property (@(posedge core_clk_i) disable iff (srst_i)
    msg_structure_fault_i |=> flags[SICR_FL_STRUCT]) // RULE13
    else $error("structure fault not flagged");

  a_pin_release: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !int_pin_enable_i |-> !int_pin_oe_o) // RULE23
    else $error("pin driven while output disabled");

  a_pin_polarity: assert property (@(posedge core_clk_i) disable iff (srst_i)
    int_pin_oe_o && int_pending_o |-> int_pin_o == int_active_high_i) // RULE24
    else $error("interrupt pin polarity wrong");

  a_enable_now: assert property (@(posedge core_clk_i) disable iff (srst_i)
    wr_en_lo && reg_wdata_i[SICR_FL_CRC_DONE] && flags[SICR_FL_CRC_DONE]
      |=> int_pending_o) // RULE26 RULE5
    else $error("enable on pending flag did not raise interrupt");

  a_even_length: assert property (@(posedge core_clk_i) disable iff (srst_i)
    wr_len_lo |=> !length[0] && !start_addr[0]) // RULE16 RULE22
    else $error("length or start address odd");

  a_fault_flag: assert property (@(posedge core_clk_i) disable iff (srst_i)
    generic_fault_i ##1 !wr_flag_lo |-> flags[SICR_FL_GENERIC]) // RULE14
    else $error("generic fault not flagged");

  a_result_low: assert property (@(posedge core_clk_i) disable iff (srst_i)
    reg_rd_i && reg_addr_i == SICR_ADDR_RES_LO |=> reg_rdata_o == $past(result[7:0])) // RULE18
    else $error("result low byte not at lower address");

  a_reset_clear: assert property (@(posedge core_clk_i)
    srst_i |=> flags == 16'h0000 && enables == 16'h0000 && !busy) // RULE7
    else $error("registers not cleared by reset");

endmodule : sicr_regs

// ---- src/sicr_pkg.sv ----
// package: register map, field positions, reset values and state codes
package sicr_pkg;

  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [15:0] SICR_ADDR_START_LO = 16'hfff2; // checksum start address, low byte
  localparam logic [15:0] SICR_ADDR_START_HI = 16'hfff3; // checksum start address, high byte
  localparam logic [15:0] SICR_ADDR_LEN_LO = 16'hfff4; // checksum length, low byte
  localparam logic [15:0] SICR_ADDR_LEN_HI = 16'hfff5; // checksum length, high byte, launches
  localparam logic [15:0] SICR_ADDR_RES_LO = 16'hfff6; // checksum result, low byte
  localparam logic [15:0] SICR_ADDR_RES_HI = 16'hfff7; // checksum result, high byte
  localparam logic [15:0] SICR_ADDR_FLAG_LO = 16'hfff8; // pending flags, low byte
  localparam logic [15:0] SICR_ADDR_FLAG_HI = 16'hfff9; // pending flags, high byte
  localparam logic [15:0] SICR_ADDR_EN_LO = 16'hfffa; // interrupt enables, low byte
  localparam logic [15:0] SICR_ADDR_EN_HI = 16'hfffb; // interrupt enables, high byte
  localparam logic [15:0] SICR_ADDR_STAT_LO = 16'hfffc; // device status, low byte
  localparam logic [15:0] SICR_ADDR_STAT_HI = 16'hfffd; // device status, high byte

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] SICR_RST_REG = 16'h0000; // every mapped register resets to zero
  localparam logic [15:0] SICR_CRC_PRESET = 16'hffff; // checksum preset
  localparam logic [15:0] SICR_CRC_POLY = 16'h1021; // x^16 + x^12 + x^5 + 1

  // ----------------------------------------
  // status bit positions
  // ----------------------------------------
  localparam int SICR_ST_MEM_READY = 0; // message memory accepts serial updates
  localparam int SICR_ST_CRC_BUSY = 1; // checksum running
  localparam int SICR_ST_RADIO = 2; // radio activity

  // ----------------------------------------
  // pending flag bit positions
  // ----------------------------------------
  localparam int SICR_FL_READ_DONE = 1; // reader_read_done
  localparam int SICR_FL_WRITE_DONE = 2; // reader_write_done
  localparam int SICR_FL_CRC_DONE = 3; // checksum finished
  localparam int SICR_FL_PARITY = 4; // interleaved_parity_fault
  localparam int SICR_FL_STRUCT = 5; // msg_structure_fault
  localparam int SICR_FL_GENERIC = 7; // generic fault
  localparam logic [15:0] SICR_FLAG_IMPL = 16'h00be; // flag bits that exist

  // ----------------------------------------
  // checksum engine states
  // ----------------------------------------
  typedef enum logic [2:0] {
    SICR_IDLE = 3'b001, // waiting for a launch
    SICR_FETCH = 3'b010, // memory read issued
    SICR_ACCUM = 3'b100 // read data folded in
  } sicr_state_t;

endpackage : sicr_pkg

// ---- testbench/sicr_mem_model.sv ----
// message memory model answering the checksum engine's byte reads
`timescale 1ns/1ns
module sicr_mem_model
#(
  parameter int ADDR_W = 16 // byte address width
)
(
  input wire logic core_clk_i, // core clock
  input wire logic mem_rd_i, // read request
  input wire logic [ADDR_W-1:0] mem_addr_i, // byte address
  output logic [7:0] mem_rdata_o = 8'h00 // byte, one cycle after the request
);
  // ----------------------------------------
  // read port
  // ----------------------------------------
  // byte pattern follows the low address byte, so the bytes of any 256-byte span differ;
  // between reads the line toggles, so a late sample never looks valid
  always @(posedge core_clk_i)
  begin
    if (mem_rd_i)
    begin
      mem_rdata_o <= mem_addr_i[7:0] ^ 8'h5a;
    end
    else
    begin
      mem_rdata_o <= ~mem_rdata_o;
    end
  end
endmodule : sicr_mem_model

// ---- testbench/sicr_regs_tb.sv ----
// self-checking testbench for the status, interrupt and checksum registers
`timescale 1ns/1ns
module sicr_regs_tb
  import sicr_pkg::*;
;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clk = 1'b0; // 50 MHz core clock
  logic srst = 1'b1; // synchronous reset
  logic wr = 1'b0, rd = 1'b0; // register strobes
  logic [15:0] addr = 16'h0000; // register byte address
  logic [7:0] wdata = 8'h00, rdata; // register bytes
  logic mem_rd, mem_ready = 1'b0, radio = 1'b0, pmode = 1'b0; // memory and state
  logic [15:0] mem_addr; // checksum fetch address
  logic [7:0] mem_rdata; // fetched byte
  logic [7:0] ev = 8'h00; // event pulses, indexed by flag position
  logic pin_en = 1'b0, act_hi = 1'b0, idle_drv = 1'b0; // pin control
  logic pin, pin_oe, pending; // interrupt outputs
  int fail_count = 0, checked = 0; // counters
  logic [15:0] v; // scratch read value

  always #10 clk = ~clk;

  sicr_regs u_dut (.core_clk_i(clk), .srst_i(srst), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .mem_rd_o(mem_rd),
    .mem_addr_o(mem_addr), .mem_rdata_i(mem_rdata), .msg_mem_ready_i(mem_ready),
    .radio_activity_i(radio), .reader_read_done_i(ev[1]), .reader_write_done_i(ev[2]),
    .interleaved_parity_mode_i(pmode), .interleaved_parity_fault_i(ev[4]),
    .msg_structure_fault_i(ev[5]), .generic_fault_i(ev[7]), .int_pin_enable_i(pin_en),
    .int_active_high_i(act_hi), .int_drive_idle_i(idle_drv), .int_pin_o(pin),
    .int_pin_oe_o(pin_oe), .int_pending_o(pending));

  sicr_mem_model u_mem (.core_clk_i(clk), .mem_rd_i(mem_rd), .mem_addr_i(mem_addr),
    .mem_rdata_o(mem_rdata));

  // ----------------------------------------
  // shared tasks; all start and end at a falling edge
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask : check

  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask : wr8

  task automatic rd8(input logic [15:0] a, output logic [7:0] d);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
    @(negedge clk);
  endtask : rd8

  task automatic rd16(input logic [15:0] a, output logic [15:0] d);
    rd8(a, d[7:0]);
    rd8(a + 16'h0001, d[15:8]);
  endtask : rd16

  task automatic pulse(input int b);
    ev[b] = 1'b1;
    @(negedge clk);
    ev[b] = 1'b0;
    @(negedge clk);
  endtask : pulse

  // checksum of one byte, msb first, no final xor
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      c = (c[15] ^ b[i]) ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
    end
    return c;
  endfunction : crc_byte

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // every mapped register reads zero; unmapped place stays zero after a write
  task automatic t_reset();
    for (int a = 16'hfff2; a <= 16'hfffc; a += 2)
    begin
      rd16(a[15:0], v);
      check("reset value", v, 16'h0000);
    end
    wr8(16'hfff0, 8'hff);
    rd16(16'hfff0, v);
    check("unmapped", v, 16'h0000);
  endtask : t_reset

  // live status bits, reserved zero, writes ignored
  task automatic t_status();
    wr8(SICR_ADDR_STAT_LO, 8'hff);
    for (int i = 0; i < 4; i++)
    begin
      mem_ready = i[0];
      radio = i[1];
      rd16(SICR_ADDR_STAT_LO, v);
      check("status", v, {13'h0000, radio, 1'b0, mem_ready});
    end
    radio = 1'b0;
  endtask : t_status

  // events set flags, write-one clears, enable gating of the interrupt
  task automatic t_flags();
    wr8(SICR_ADDR_EN_LO, 8'ha5);
    wr8(SICR_ADDR_EN_HI, 8'h5a);
    rd16(SICR_ADDR_EN_LO, v);
    check("enables", v, 16'h5aa5);
    wr8(SICR_ADDR_EN_LO, 8'h00);
    wr8(SICR_ADDR_EN_HI, 8'h00);
    pulse(4);
    rd16(SICR_ADDR_FLAG_LO, v);
    check("parity off", v, 16'h0000);
    pmode = 1'b1;
    for (int b = 0; b < 16; b++)
      if (SICR_FLAG_IMPL[b] && b != SICR_FL_CRC_DONE)
        pulse(b);
    rd16(SICR_ADDR_FLAG_LO, v);
    check("flags set", v, 16'h00b6);
    check("no enable", {15'h0000, pending}, 16'h0000);
    wr8(SICR_ADDR_EN_LO, 8'h04);
    check("late enable", {15'h0000, pending}, 16'h0001);
    wr8(SICR_ADDR_FLAG_LO, 8'h04);
    rd16(SICR_ADDR_FLAG_LO, v);
    check("w1c", v, 16'h00b2);
    check("cleared", {15'h0000, pending}, 16'h0000);
    // event and clear of the same flag in one cycle: the event must survive
    addr = SICR_ADDR_FLAG_LO;
    wdata = 8'h04;
    wr = 1'b1;
    ev[2] = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    ev[2] = 1'b0;
    @(negedge clk);
    rd16(SICR_ADDR_FLAG_LO, v);
    check("set wins", v, 16'h00b6);
    wr8(SICR_ADDR_FLAG_LO, 8'hff);
    wr8(SICR_ADDR_EN_LO, 8'h08);
  endtask : t_flags

  // checksum over an odd-programmed range, then a zero-length launch
  task automatic t_crc();
    int n;
    logic [7:0] s;
    n = 0;
    radio = 1'b0;
    wr8(SICR_ADDR_START_LO, 8'h11);
    wr8(SICR_ADDR_START_HI, 8'h00);
    wr8(SICR_ADDR_LEN_LO, 8'h03);
    wr8(SICR_ADDR_LEN_HI, 8'h00);
    rd8(SICR_ADDR_STAT_LO, s);
    check("busy", {15'h0000, s[1]}, 16'h0001);
    while (s[1] === 1'b1 && n < 50)
    begin
      rd8(SICR_ADDR_STAT_LO, s);
      n++;
    end
    if (n >= 50)
    begin
      check("busy timeout", 16'h0001, 16'h0000);
      give_verdict();
    end
    rd16(SICR_ADDR_FLAG_LO, v);
    check("done flag", v, 16'h0008);
    check("done irq", {15'h0000, pending}, 16'h0001);
    rd16(SICR_ADDR_RES_LO, v);
    check("result", v, crc_byte(crc_byte(16'hffff, 8'h4a), 8'h4b));
    rd16(SICR_ADDR_START_LO, v);
    check("start", v, 16'h0010);
    rd16(SICR_ADDR_LEN_LO, v);
    check("length", v, 16'h0002);
    wr8(SICR_ADDR_FLAG_LO, 8'h08);
    wr8(SICR_ADDR_LEN_LO, 8'h00);
    wr8(SICR_ADDR_LEN_HI, 8'h00);
    rd16(SICR_ADDR_RES_LO, v);
    check("empty result", v, SICR_CRC_PRESET);
  endtask : t_crc

  // pin enable, polarity and idle drive against pending state
  task automatic t_pin();
    logic oe;
    for (int p = 0; p < 2; p++)
    begin
      wr8(SICR_ADDR_EN_LO, p[0] ? 8'h08 : 8'h00);
      for (int k = 0; k < 8; k++)
      begin
        pin_en = k[0];
        act_hi = k[1];
        idle_drv = k[2];
        @(negedge clk);
        oe = k[0] && (p[0] || k[2]);
        check("pin oe", {15'h0000, pin_oe}, {15'h0000, oe});
        if (oe)
          check("pin level", {15'h0000, pin}, {15'h0000, ~(k[1] ^ p[0])});
      end
    end
  endtask : t_pin

  // ----------------------------------------
  // main sequence and hang guard
  // ----------------------------------------
  initial
  begin
    repeat (10) @(negedge clk);
    srst = 1'b0;
    t_reset();
    t_status();
    t_flags();
    t_crc();
    t_pin();
    give_verdict();
  end

  initial
  begin
    #1000000;
    fail_count++;
    give_verdict();
  end
endmodule : sicr_regs_tb
